/* verilog/xbp_map.svh */
`ifndef XBP_MAP_SVH
`define XBP_MAP_SVH
`define XBP_ADDR_W      24
`define XBP_DATA_W      32
`define XBP_SHORT_W     16
`define XBP_BANK_LSB    24
`define XBP_BANK_N      4
`define XBP_IRQ_N       3
`define XBP_FLAG_N      12
`define XBP_SLV_WAIT    2
`define XBP_IOP_DEPTH   16
`endif

/* verilog/xbp_pkg.sv */
package xbp_pkg;
  typedef enum logic [3:0] {
    xbp_idle   = 4'h1,
    xbp_setup  = 4'h2,
    xbp_strobe = 4'h4,
    xbp_finish = 4'h8
  } xbp_mst_state_type;
  typedef enum logic [2:0] {
    xbs_idle = 3'h1,
    xbs_wait = 3'h2,
    xbs_done = 3'h4
  } xbp_slv_state_type;
endpackage

/* verilog/xbp_bus_if.sv */
`timescale 1ns/1ps
`include "xbp_map.svh"
interface xbp_bus_if;
  // address, data, bank selects, strobes, write select, acknowledge
  logic [`XBP_ADDR_W-1:0] m_addr_o;
  logic                   m_addr_oe;
  logic [`XBP_ADDR_W-1:0] s_addr_o;
  logic                   s_addr_oe;
  logic [`XBP_DATA_W-1:0] m_data_o;
  logic                   m_data_oe;
  logic [`XBP_DATA_W-1:0] s_data_o;
  logic                   s_data_oe;
  logic [`XBP_BANK_N-1:0] m_bank_select_n;
  logic                   m_ctl_oe;
  logic                   m_rd_n;
  logic                   m_wr_n;
  logic                   m_early_write_select_n;
  logic                   s_ack_o;
  logic                   s_ack_oe;
  logic                   bus_suspend_tristate_n;
  // resolved wire levels; floating lines read as idle, ack keeps its last level
  logic [`XBP_ADDR_W-1:0] addr;
  logic [`XBP_DATA_W-1:0] data;
  logic [`XBP_BANK_N-1:0] bank_select_n;
  logic                   rd_n;
  logic                   wr_n;
  logic                   early_write_select_n;
  logic                   ack;
  assign addr = m_addr_oe ? m_addr_o : (s_addr_oe ? s_addr_o : '0);
  assign data = m_data_oe ? m_data_o : (s_data_oe ? s_data_o : '0);
  assign bank_select_n = m_ctl_oe ? m_bank_select_n : '1;
  assign rd_n = m_ctl_oe ? m_rd_n : 1'b1;
  assign wr_n = m_ctl_oe ? m_wr_n : 1'b1;
  assign early_write_select_n = m_ctl_oe ? m_early_write_select_n : 1'b1;
  // slave always leaves ack high before letting go, so high is the kept level
  assign ack = s_ack_oe ? s_ack_o : 1'b1;
  modport master (
    output m_addr_o, m_addr_oe, m_data_o, m_data_oe, m_bank_select_n, m_ctl_oe,
    output m_rd_n, m_wr_n, m_early_write_select_n,
    input  data, ack, bus_suspend_tristate_n
  );
  modport slave (
    output s_addr_o, s_addr_oe, s_data_o, s_data_oe, s_ack_o, s_ack_oe,
    input  addr, data, bank_select_n, rd_n, wr_n, early_write_select_n
  );
endinterface

/* verilog/xbp_irq_flag.sv */
`timescale 1ns/1ps
`include "xbp_map.svh"
module xbp_irq_flag
  import xbp_pkg::*;
#(
  parameter int IRQ_N  = `XBP_IRQ_N,
  parameter int FLAG_N = `XBP_FLAG_N
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [IRQ_N-1:0]  irq_n_pin,
  input  wire logic [IRQ_N-1:0]  irq_edge_mode,
  input  wire logic [FLAG_N-1:0] flag_pin_i,
  input  wire logic [FLAG_N-1:0] flag_dir_out,
  input  wire logic [FLAG_N-1:0] flag_out_val,
  output logic      [IRQ_N-1:0]  irq_req,
  output logic      [FLAG_N-1:0] flag_cond,
  output logic      [FLAG_N-1:0] flag_pin_o,
  output logic      [FLAG_N-1:0] flag_pin_oe
);
  logic [IRQ_N-1:0]  irq_s1, irq_s2, irq_s3;
  logic [IRQ_N-1:0]  next_irq_req;
  logic [FLAG_N-1:0] flag_s1, flag_s2;
  logic [FLAG_N-1:0] next_flag_cond;

  // per-line edge or level request, flags as input condition or output
  genvar g;
  generate
    for (g = 0; g < IRQ_N; g++) begin : g_irq
      always_comb begin
        if (irq_edge_mode[g]) begin
          next_irq_req[g] = irq_s3[g] & ~irq_s2[g];
        end else begin
          next_irq_req[g] = ~irq_s2[g];
        end
      end
    end
    for (g = 0; g < FLAG_N; g++) begin : g_flag
      always_comb begin
        next_flag_cond[g] = flag_dir_out[g] ? flag_out_val[g] : flag_s2[g];
      end
    end
  endgenerate

  // synchronisers and registered outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_s1      <= '1;
      irq_s2      <= '1;
      irq_s3      <= '1;
      flag_s1     <= '0;
      flag_s2     <= '0;
      irq_req     <= '0;
      flag_cond   <= '0;
      flag_pin_o  <= '0;
      flag_pin_oe <= '0;
    end else begin
      irq_s1      <= irq_n_pin;
      irq_s2      <= irq_s1;
      irq_s3      <= irq_s2;
      flag_s1     <= flag_pin_i;
      flag_s2     <= flag_s1;
      irq_req     <= next_irq_req;
      flag_cond   <= next_flag_cond;
      flag_pin_o  <= flag_out_val;
      flag_pin_oe <= flag_dir_out;
    end
  end
endmodule

/* verilog/xbp_master_end.sv */
`timescale 1ns/1ps
`include "xbp_map.svh"
module xbp_master_end
  import xbp_pkg::*;
#(
  parameter int ADDR_W = `XBP_ADDR_W,
  parameter int DATA_W = `XBP_DATA_W
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  xbp_bus_if.master                   bus,
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire logic                   req_short,
  input  wire logic                   req_cond_true,
  input  wire logic                   req_is_master,
  input  wire logic                   req_sdram_bank,
  input  wire logic [ADDR_W+1:0]      req_addr,
  input  wire logic [DATA_W-1:0]      req_wdata,
  input  wire logic [`XBP_IRQ_N-1:0]  irq_n_pin,
  input  wire logic [`XBP_IRQ_N-1:0]  irq_edge_mode,
  input  wire logic [`XBP_FLAG_N-1:0] flag_pin_i,
  input  wire logic [`XBP_FLAG_N-1:0] flag_dir_out,
  input  wire logic [`XBP_FLAG_N-1:0] flag_out_val,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic      [DATA_W-1:0]      rsp_rdata,
  output logic      [`XBP_IRQ_N-1:0]  irq_req,
  output logic      [`XBP_FLAG_N-1:0] flag_cond,
  output logic      [`XBP_FLAG_N-1:0] flag_pin_o,
  output logic      [`XBP_FLAG_N-1:0] flag_pin_oe
);
  xbp_mst_state_type             state, next_state;
  logic [ADDR_W-1:0]             addr_q, next_addr_q;
  logic [DATA_W-1:0]             wdata_q, next_wdata_q;
  logic [`XBP_BANK_N-1:0]        sel_n, next_sel_n;
  logic                          rd_n, next_rd_n;
  logic                          wr_n, next_wr_n;
  logic                          ews_n, next_ews_n;
  logic                          write_q, next_write_q;
  logic                          short_q, next_short_q;
  logic                          cond_q, next_cond_q;
  logic                          sdram_q, next_sdram_q;
  logic                          drive, next_drive;
  logic                          settle, next_settle;
  logic                          ready, next_ready;
  logic                          rvalid, next_rvalid;
  logic [DATA_W-1:0]             rdata, next_rdata;
  logic                          sus_s1, sus_s2;

  // one-hot bank select from the two upper internal address bits
  function automatic logic [`XBP_BANK_N-1:0] bank_decode(input logic [1:0] b);
    bank_decode = ~(`XBP_BANK_N'(1) << b);
  endfunction

  // flag and interrupt pins
  xbp_irq_flag u_irq_flag (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .irq_n_pin     (irq_n_pin),
    .irq_edge_mode (irq_edge_mode),
    .flag_pin_i    (flag_pin_i),
    .flag_dir_out  (flag_dir_out),
    .flag_out_val  (flag_out_val),
    .irq_req       (irq_req),
    .flag_cond     (flag_cond),
    .flag_pin_o    (flag_pin_o),
    .flag_pin_oe   (flag_pin_oe)
  );

  // pins come straight from the registered state
  assign bus.m_addr_o               = addr_q;
  assign bus.m_addr_oe              = drive;
  assign bus.m_data_o               = short_q ? {16'h0000, wdata_q[`XBP_SHORT_W-1:0]}
                                              : wdata_q;
  assign bus.m_data_oe              = drive & write_q & ~wr_n;
  assign bus.m_bank_select_n        = sel_n;
  assign bus.m_ctl_oe               = drive;
  assign bus.m_rd_n                 = rd_n;
  assign bus.m_wr_n                 = wr_n;
  assign bus.m_early_write_select_n = ews_n;
  assign req_ready                  = ready;
  assign rsp_valid                  = rvalid;
  assign rsp_rdata                  = rdata;

  // access sequencing
  always_comb begin
    next_state    = state;
    next_addr_q   = addr_q;
    next_wdata_q  = wdata_q;
    next_sel_n    = sel_n;
    next_rd_n     = 1'b1;
    next_wr_n     = 1'b1;
    next_ews_n    = 1'b1;
    next_write_q  = write_q;
    next_short_q  = short_q;
    next_cond_q   = cond_q;
    next_sdram_q  = sdram_q;
    next_drive    = drive;
    next_ready    = 1'b0;
    next_rvalid   = 1'b0;
    next_rdata    = rdata;
    next_settle   = 1'b0;
    case (state)
      xbp_idle: begin
        next_sel_n = sdram_q ? sel_n : '1;
        next_drive = 1'b0;
        if (req_valid && req_is_master && !sus_s2) begin
          next_state   = xbp_setup;
          next_addr_q  = req_addr[ADDR_W-1:0];
          next_sel_n   = bank_decode(req_addr[`XBP_BANK_LSB+1:`XBP_BANK_LSB]);
          next_ews_n   = ~req_write;
          next_write_q = req_write;
          next_short_q = req_short;
          next_cond_q  = req_cond_true;
          next_sdram_q = req_sdram_bank;
          next_wdata_q = req_wdata;
          next_drive   = 1'b1;
        end
      end
      xbp_setup: begin
        next_ews_n = ~write_q;
        if (sus_s2) begin
          next_drive = 1'b0;
        end else begin
          next_drive = 1'b1;
          if (!cond_q) begin
            next_state = xbp_finish;
          end else begin
            next_state  = xbp_strobe;
            next_settle = 1'b1;
            next_rd_n   = write_q;
            next_wr_n  = ~write_q;
          end
        end
      end
      xbp_strobe: begin
        next_ews_n = ~write_q;
        if (sus_s2) begin
          next_drive = 1'b0;
          next_state = xbp_setup;
        end else if (settle || !bus.ack) begin // slave ack falls a cycle after strobe
          next_rd_n = rd_n;
          next_wr_n = wr_n;
        end else begin
          next_state = xbp_finish;
          next_rdata = short_q ? {16'h0000, bus.data[`XBP_SHORT_W-1:0]} : bus.data;
        end
      end
      xbp_finish: begin
        next_state  = xbp_idle;
        next_ready  = 1'b1;
        next_rvalid = cond_q & ~write_q;
        next_sel_n  = sdram_q ? sel_n : '1;
        next_drive  = 1'b0;
      end
      default: begin
        next_state = xbp_idle;
      end
    endcase
  end

  // registers of the master end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state    <= xbp_idle;
      addr_q   <= '0;
      wdata_q  <= '0;
      sel_n    <= '1;
      rd_n     <= 1'b1;
      wr_n     <= 1'b1;
      ews_n    <= 1'b1;
      write_q  <= 1'b0;
      short_q  <= 1'b0;
      cond_q   <= 1'b0;
      sdram_q  <= 1'b0;
      drive    <= 1'b0;
      settle   <= 1'b0;
      ready    <= 1'b0;
      rvalid   <= 1'b0;
      rdata    <= '0;
      sus_s1   <= 1'b0;
      sus_s2   <= 1'b0;
    end else begin
      state    <= next_state;
      addr_q   <= next_addr_q;
      wdata_q  <= next_wdata_q;
      sel_n    <= next_sel_n;
      rd_n     <= next_rd_n;
      wr_n     <= next_wr_n;
      ews_n    <= next_ews_n;
      write_q  <= next_write_q;
      short_q  <= next_short_q;
      cond_q   <= next_cond_q;
      sdram_q  <= next_sdram_q;
      drive    <= next_drive;
      settle   <= next_settle;
      ready    <= next_ready;
      rvalid   <= next_rvalid;
      rdata    <= next_rdata;
      sus_s1   <= ~bus.bus_suspend_tristate_n;
      sus_s2   <= sus_s1;
    end
  end
endmodule

/* verilog/xbp_slave_end.sv */
`timescale 1ns/1ps
`include "xbp_map.svh"
module xbp_slave_end
  import xbp_pkg::*;
#(
  parameter int DATA_W = `XBP_DATA_W,
  parameter int DEPTH  = `XBP_IOP_DEPTH,
  parameter int WAIT_N = `XBP_SLV_WAIT
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  xbp_bus_if.slave               bus,
  output logic                   acc_valid,
  output logic                   acc_write,
  output logic [$clog2(DEPTH)-1:0] acc_index,
  output logic [DATA_W-1:0]      acc_wdata
);
  localparam int IW = $clog2(DEPTH);
  xbp_slv_state_type state, next_state;
  logic [DATA_W-1:0] io_processor_register [DEPTH];
  logic [IW-1:0]     idx, next_idx;
  logic              wr, next_wr;
  logic [3:0]        cnt, next_cnt;
  logic              ack_o, next_ack_o;
  logic              ack_oe, next_ack_oe;
  logic              dout_oe, next_dout_oe;
  logic [DATA_W-1:0] dout, next_dout;
  logic              av, next_av;

  assign bus.s_addr_o  = '0;
  assign bus.s_addr_oe = 1'b0;
  assign bus.s_data_o  = dout;
  assign bus.s_data_oe = dout_oe;
  assign bus.s_ack_o   = ack_o;
  assign bus.s_ack_oe  = ack_oe;
  assign acc_valid     = av;
  assign acc_write     = wr;
  assign acc_index     = idx;
  assign acc_wdata     = io_processor_register[idx];

  // slave access sequencing with wait states
  always_comb begin
    next_state   = state;
    next_idx     = idx;
    next_wr      = wr;
    next_cnt     = cnt;
    next_ack_o   = ack_o;
    next_ack_oe  = ack_oe;
    next_dout_oe = 1'b0;
    next_dout    = dout;
    next_av      = 1'b0;
    case (state)
      xbs_idle: begin
        next_ack_oe = 1'b0;
        if (!bus.rd_n || !bus.wr_n) begin
          next_idx    = bus.addr[IW-1:0];
          next_wr     = ~bus.early_write_select_n;
          next_cnt    = 4'(WAIT_N);
          next_ack_o  = 1'b0;
          next_ack_oe = 1'b1;
          next_state  = xbs_wait;
        end
      end
      xbs_wait: begin
        if (cnt == 4'h0) begin
          next_ack_o   = 1'b1;
          next_dout    = io_processor_register[idx];
          next_dout_oe = ~wr;
          next_av      = 1'b1;
          next_state   = xbs_done;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      xbs_done: begin
        next_dout_oe = ~wr & ~bus.rd_n;
        if (bus.rd_n && bus.wr_n) begin
          next_ack_oe = 1'b0;
          next_state  = xbs_idle;
        end
      end
      default: begin
        next_state = xbs_idle;
      end
    endcase
  end

  // register storage; short writes store the whole word, upper half cleared by the master
  always_ff @(posedge sys_clk) begin
    if (state == xbs_wait && cnt == 4'h0 && wr) begin
      io_processor_register[idx] <= bus.data;
    end
  end

  // slave registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state   <= xbs_idle;
      idx     <= '0;
      wr      <= 1'b0;
      cnt     <= 4'h0;
      ack_o   <= 1'b1;
      ack_oe  <= 1'b0;
      dout_oe <= 1'b0;
      dout    <= '0;
      av      <= 1'b0;
    end else begin
      state   <= next_state;
      idx     <= next_idx;
      wr      <= next_wr;
      cnt     <= next_cnt;
      ack_o   <= next_ack_o;
      ack_oe  <= next_ack_oe;
      dout_oe <= next_dout_oe;
      dout    <= next_dout;
      av      <= next_av;
    end
  end
endmodule

/* verif/xbp_bus_checker.sv */
`timescale 1ns/1ps
`include "xbp_map.svh"
module xbp_bus_checker
  import xbp_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic [`XBP_ADDR_W-1:0] addr,
  input wire logic [`XBP_BANK_N-1:0] bank_select_n,
  input wire logic                   rd_n,
  input wire logic                   wr_n,
  input wire logic                   early_write_select_n,
  input wire logic                   ack,
  input wire logic                   bus_suspend_tristate_n,
  input wire logic                   m_ctl_oe,
  input wire logic                   m_addr_oe,
  input wire logic                   m_data_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a strobe held through a wait, then acknowledged
  sequence s_rd_ack;
    !rd_n && !ack ##1 !rd_n && ack;
  endsequence
  sequence s_wr_ack;
    !wr_n && !ack ##1 !wr_n && ack;
  endsequence
  // strobe release follows the acknowledge by one cycle
  a_rd_release: assert property (s_rd_ack |=> rd_n)
    else $error("read strobe not released after ack");
  a_wr_release: assert property (s_wr_ack |=> wr_n)
    else $error("write strobe not released after ack");
  // lines frozen while the slave stretches the access
  a_wait_hold: assert property ((!rd_n || !wr_n) && !ack && bus_suspend_tristate_n
    |=> $stable(addr) && $stable(bank_select_n) && $stable(rd_n) && $stable(wr_n))
    else $error("address or strobe moved during wait");
  // slave inserts waits, bounded
  a_slave_wait: assert property (($fell(rd_n) || $fell(wr_n)) |=> !ack ##[1:6] ack)
    else $error("slave ack wait missing or too long");
  a_sel_onehot: assert property (!(&bank_select_n) |-> $onehot(~bank_select_n))
    else $error("more than one bank select active");
  a_strobe_sel: assert property ((!rd_n || !wr_n) |-> !(&bank_select_n) && m_addr_oe)
    else $error("strobe without address and bank select");
  a_ews_addr: assert property ($fell(early_write_select_n) |-> m_addr_oe && !(&bank_select_n))
    else $error("early write select without address");
  a_wr_ews_data: assert property (!wr_n |-> !early_write_select_n && m_data_oe)
    else $error("write strobe without write select or data");
  a_rd_no_ews: assert property (!rd_n |-> early_write_select_n && !m_data_oe)
    else $error("read strobe with write select or data drive");
  // suspend passes a two-stage sync and one register before the pins float
  a_suspend_float: assert property (!bus_suspend_tristate_n [*3]
    |=> !m_ctl_oe && !m_addr_oe && !m_data_oe)
    else $error("bus still driven under suspend");
endmodule

/* verif/test_dsp_external_bus_port.sv */
`timescale 1ns/1ps
`include "xbp_map.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module test_dsp_external_bus_port
  import xbp_pkg::*;
;
  logic        sys_clk, rst, req_valid, req_write, req_short, req_cond_true;
  logic        req_is_master, req_sdram_bank, req_ready, rsp_valid;
  logic        acc_valid, acc_write, got_rv, acc_seen, acc_wr_seen, ews_seen;
  logic [25:0] req_addr;
  logic [31:0] req_wdata, rsp_rdata, acc_wdata, got_rd, cap_data;
  logic [2:0]  irq_n_pin, irq_edge_mode, irq_req;
  logic [11:0] flag_pin_i, flag_dir_out, flag_out_val, flag_cond, flag_pin_o, flag_pin_oe;
  logic [3:0]  acc_index, cap_bank, sel_bank;
  logic [23:0] cap_addr;
  int          n_fail, num_checks, strobes, ack_lo;
  xbp_bus_if bus ();
  xbp_master_end xbp_master_end_i (
    .sys_clk(sys_clk), .rst(rst), .bus(bus), .req_valid(req_valid),
    .req_write(req_write), .req_short(req_short), .req_cond_true(req_cond_true),
    .req_is_master(req_is_master), .req_sdram_bank(req_sdram_bank),
    .req_addr(req_addr), .req_wdata(req_wdata), .irq_n_pin(irq_n_pin),
    .irq_edge_mode(irq_edge_mode), .flag_pin_i(flag_pin_i), .flag_dir_out(flag_dir_out),
    .flag_out_val(flag_out_val), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .irq_req(irq_req), .flag_cond(flag_cond),
    .flag_pin_o(flag_pin_o), .flag_pin_oe(flag_pin_oe)
  );
  xbp_slave_end xbp_slave_end_i (
    .sys_clk(sys_clk), .rst(rst), .bus(bus), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_index(acc_index), .acc_wdata(acc_wdata)
  );
  xbp_bus_checker xbp_bus_checker_i (
    .sys_clk(sys_clk), .rst(rst), .addr(bus.addr), .bank_select_n(bus.bank_select_n),
    .rd_n(bus.rd_n), .wr_n(bus.wr_n), .early_write_select_n(bus.early_write_select_n),
    .ack(bus.ack), .bus_suspend_tristate_n(bus.bus_suspend_tristate_n),
    .m_ctl_oe(bus.m_ctl_oe), .m_addr_oe(bus.m_addr_oe), .m_data_oe(bus.m_data_oe)
  );
  // bus monitor: records what the wire showed during each access
  always @(posedge sys_clk) begin
    if (!bus.rd_n || !bus.wr_n) begin
      strobes++;
      cap_addr = bus.addr;
      cap_bank = bus.bank_select_n;
      cap_data = bus.data;
      if (!bus.ack) ack_lo++;
    end
    if (!(&bus.bank_select_n)) sel_bank = bus.bank_select_n;
    if (!bus.early_write_select_n) ews_seen = 1'b1;
    if (acc_valid) begin
      acc_seen = 1'b1;
      acc_wr_seen = acc_write;
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // raise one request, one edge after the previous one ended
  task automatic start(input logic wr, sh, cond, input logic [25:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1;
    strobes = 0;
    ack_lo = 0;
    acc_seen = 1'b0;
    acc_wr_seen = 1'bx;
    ews_seen = 1'b0;
    sel_bank = 4'hf;
    req_write = wr;
    req_short = sh;
    req_cond_true = cond;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
  endtask
  // hold the request until the finish pulse, bounded
  task automatic wait_done;
    int k;
    k = 0;
    while (req_ready !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      k++;
      if (k > 100) begin
        n_fail++;
        $display("unexpected at %0t: access never finished", $time);
        tally_and_finish();
      end
    end
    got_rv = rsp_valid;
    got_rd = rsp_rdata;
    req_valid = 1'b0;
  endtask
  task automatic t_idle;
    `CHK(bus.bank_select_n, 4'hf)
    `CHK(bus.rd_n & bus.wr_n & bus.early_write_select_n, 1'b1)
    `CHK(bus.m_ctl_oe, 1'b0)
    $display("test idle done");
  endtask
  // write then read back through each bank
  task automatic t_banks;
    logic [25:0] a;
    logic [31:0] d;
    for (int b = 0; b < 4; b++) begin
      a = {2'(b), 24'hc3a5f0 + 24'(b * 3)};
      d = 32'h5a00_0000 | 32'(b);
      start(1'b1, 1'b0, 1'b1, a, d);
      wait_done();
      `CHK((strobes > 0), 1'b1)
      `CHK(cap_addr, a[23:0])
      `CHK(cap_bank, ~(4'h1 << b))
      `CHK(ews_seen, 1'b1)
      `CHK(acc_wr_seen, 1'b1)
      `CHK(acc_index, a[3:0])
      `CHK(acc_wdata, d)
      `CHK((ack_lo >= 2), 1'b1)
      start(1'b0, 1'b0, 1'b1, a, 32'h0);
      wait_done();
      `CHK(got_rv, 1'b1)
      `CHK(got_rd, d)
      `CHK(acc_wr_seen, 1'b0)
      `CHK(ews_seen, 1'b0)
    end
    $display("test banks done");
  endtask
  task automatic t_short;
    start(1'b1, 1'b1, 1'b1, {2'h2, 24'h000107}, 32'h89ab_cdef);
    wait_done();
    `CHK(cap_data, 32'h0000_cdef)
    `CHK(acc_wdata, 32'h0000_cdef)
    $display("test short done");
  endtask
  // false conditional write: selects and warning only
  task automatic t_false;
    start(1'b1, 1'b0, 1'b0, {2'h1, 24'h000042}, 32'hdead_0001);
    wait_done();
    `CHK((strobes == 0), 1'b1)
    `CHK(sel_bank, 4'hd)
    `CHK(ews_seen, 1'b1)
    `CHK(acc_seen, 1'b0)
    $display("test false conditional done");
  endtask
  task automatic t_suspend;
    int k;
    bus.bus_suspend_tristate_n = 1'b0;
    start(1'b1, 1'b0, 1'b1, {2'h3, 24'h00000c}, 32'h0bad_f00d);
    repeat (6) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK(bus.m_ctl_oe, 1'b0)
    `CHK(bus.m_addr_oe, 1'b0)
    `CHK(req_ready, 1'b0)
    `CHK((strobes == 0), 1'b1)
    bus.bus_suspend_tristate_n = 1'b1;
    wait_done();
    `CHK(acc_index, 4'hc)
    `CHK(acc_wdata, 32'h0bad_f00d)
    // suspend in the middle of a stretched read, then resume it
    start(1'b0, 1'b0, 1'b1, {2'h3, 24'h00000c}, 32'h0);
    k = 0;
    while (strobes == 0) begin
      @(posedge sys_clk);
      #1;
      k++;
      if (k > 20) begin
        n_fail++;
        $display("unexpected at %0t: read strobe never seen", $time);
        tally_and_finish();
      end
    end
    bus.bus_suspend_tristate_n = 1'b0;
    repeat (4) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK(bus.m_ctl_oe | bus.m_addr_oe | bus.m_data_oe, 1'b0)
    `CHK(req_ready, 1'b0)
    bus.bus_suspend_tristate_n = 1'b1;
    wait_done();
    `CHK(got_rv, 1'b1)
    `CHK(got_rd, 32'h0bad_f00d)
    $display("test suspend done");
  endtask
  task automatic t_not_master;
    @(posedge sys_clk);
    #1;
    req_is_master = 1'b0;
    req_valid = 1'b1;
    repeat (5) begin
      @(posedge sys_clk);
      #1;
      `CHK(bus.m_ctl_oe, 1'b0)
      `CHK(req_ready, 1'b0)
    end
    req_valid = 1'b0;
    req_is_master = 1'b1;
    $display("test not master done");
  endtask
  task automatic t_irq_flag;
    int cnt;
    cnt = 0;
    irq_n_pin = 3'b100;
    flag_dir_out = 12'h00f;
    flag_out_val = 12'h005;
    flag_pin_i = 12'ha50;
    repeat (10) begin
      @(posedge sys_clk);
      #1;
      cnt += int'(irq_req[1] === 1'b1);
    end
    `CHK((cnt == 1), 1'b1)
    `CHK(irq_req[0], 1'b1)
    `CHK(irq_req[2], 1'b0)
    `CHK(flag_pin_oe, 12'h00f)
    `CHK(flag_pin_o & 12'h00f, 12'h005)
    `CHK(flag_cond & 12'hff0, 12'ha50)
    $display("test irq and flags done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_short = 1'b0;
    req_cond_true = 1'b1;
    req_is_master = 1'b1;
    req_sdram_bank = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    irq_n_pin = 3'b111;
    irq_edge_mode = 3'b010;
    flag_pin_i = '0;
    flag_dir_out = '0;
    flag_out_val = '0;
    bus.bus_suspend_tristate_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_idle();
    t_banks();
    t_short();
    t_false();
    t_suspend();
    t_not_master();
    t_irq_flag();
    tally_and_finish();
  end
endmodule
